// *** bench/fcsi_core_asserts.sv ***
// port checker for the flash command and status interface
// assumes bind into fcsi_core, one clock, async active-low reset
`timescale 1ns/1ps
module fcsi_core_asserts
    import fcsi_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic key_write_o,
    input wire logic [15:0] key_addr_o,
    input wire logic array_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic rd_ack;
    logic [4:0] ofs;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign ofs = wb_adr_i[4:0];
    // --------------------------------------------------------
    // bus handshake
    // --------------------------------------------------------
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    hi_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    // --------------------------------------------------------
    // register read-back
    // --------------------------------------------------------
    cfg_bits_a: assert property (
        rd_ack && ofs == {1'b0, FCSI_OFS_CONFIG} |->
        (wb_dat_o[7:0] & 8'hDF) == 8'h00)
        else $error("config reads stray bits");
    prot_lsb_a: assert property (
        rd_ack && ofs == {1'b0, FCSI_OFS_PROTECT} |-> !wb_dat_o[0])
        else $error("protect bit zero set");
    stat_fixed_a: assert property (
        rd_ack && ofs == {1'b0, FCSI_OFS_STATUS} |->
        (wb_dat_o[7:0] & 8'h0B) == 8'h00)
        else $error("status fixed bits set");
    busy_ccf_a: assert property (
        rd_ack && ofs == {1'b0, FCSI_OFS_STATUS} && $past(array_busy_o)
        |-> !wb_dat_o[FCSI_ST_CCF_BIT])
        else $error("complete flag high while busy");
    // --------------------------------------------------------
    // key window
    // --------------------------------------------------------
    key_window_a: assert property (
        key_write_o |-> key_addr_o >= FCSI_KEY_LO &&
        key_addr_o <= FCSI_KEY_HI)
        else $error("key write outside window");
    key_pulse_a: assert property (key_write_o |=> !key_write_o)
        else $error("key write not a pulse");
endmodule // fcsi_core_asserts
bind fcsi_core fcsi_core_asserts u_fcsi_core_asserts (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .key_write_o(key_write_o),
    .key_addr_o(key_addr_o),
    .array_busy_o(array_busy_o)
);

// *** bench/fcsi_core_bench.sv ***
// self-checking bench for the flash command and status interface
// assumes fcsi_core with wishbone classic slave, 250 MHz clock
`timescale 1ns/1ps
module fcsi_core_bench
    import fcsi_pkg::*;
;
    localparam logic [4:0] O_DIV = {1'b0, FCSI_OFS_DIVIDER};
    localparam logic [4:0] O_CFG = {1'b0, FCSI_OFS_CONFIG};
    localparam logic [4:0] O_PROT = {1'b0, FCSI_OFS_PROTECT};
    localparam logic [4:0] O_ST = {1'b0, FCSI_OFS_STATUS};
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] wb_adr = 32'h0000_0000;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic dbg = 1'b0;
    logic stop_req = 1'b0;
    logic prot_dis = 1'b0;
    logic erased = 1'b1;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic key_write_o;
    logic [15:0] key_addr_o;
    logic [7:0] key_data_o;
    logic [15:0] array_addr_o;
    logic [7:0] array_data_o;
    logic [7:0] array_cmd_o;
    logic [1:0] security_code_o;
    logic key_seen = 1'b0;
    logic [15:0] key_a = 16'h0000;
    logic [7:0] key_d = 8'h00;
    logic [7:0] q;
    logic [7:0] codes [5] = '{FCSI_CMD_BLANK, FCSI_CMD_BYTE, FCSI_CMD_BURST,
                              FCSI_CMD_PAGE, FCSI_CMD_MASS};
    int bad_count = 0;
    int n_checks = 0;
    always #2 core_clk = ~core_clk;
    fcsi_core #(.ADDR_W(16), .OP_PULSES(4)) u_fcsi_core (
        .core_clk_i(core_clk), .nrst_i(nrst), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel),
        .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack_o), .dbg_access_i(dbg),
        .nonvolatile_protect_copy_i(8'hFF), .nv_security_i(2'h1),
        .protection_disable_i(prot_dis), .stop_req_i(stop_req),
        .array_word_erased_i(erased), .key_write_o(key_write_o),
        .key_addr_o(key_addr_o), .key_data_o(key_data_o), .array_busy_o(),
        .array_cmd_o(array_cmd_o), .array_addr_o(array_addr_o),
        .array_data_o(array_data_o),
        .security_code_o(security_code_o));
    always @(posedge core_clk) begin
        if (key_write_o === 1'b1) begin
            key_seen <= 1'b1;
            key_a <= key_addr_o;
            key_d <= key_data_o;
        end
    end
    // --------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [4:0] o,
                        input logic [15:0] fa, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hF;
        wb_adr <= {fa, 11'h000, o};
        wb_dat <= {24'h00_0000, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64) bad_count++;
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] o, input logic [7:0] d,
                      input logic [15:0] fa = 16'h0000);
        xfer(1'b1, o, fa, d);
    endtask
    task automatic rd_chk(input logic [4:0] o, input logic [7:0] e);
        xfer(1'b0, o, 16'h0000, 8'h00);
        check(q, e);
    endtask
    task automatic launch(input logic [15:0] fa, input logic [7:0] c);
        wr(FCSI_OFS_ARRAY, 8'hA5, fa);
        wr(FCSI_OFS_COMMAND, c);
        wr(O_ST, 8'h80);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            xfer(1'b0, O_ST, 16'h0000, 8'h00);
            n++;
        end while (q[FCSI_ST_CCF_BIT] !== 1'b1 && n < 200);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end
    // --------------------------------------------------------
    // test sequence
    // --------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd_chk(O_PROT, 8'hFE);
        rd_chk(O_ST, 8'hC0);
        check({6'h00, security_code_o}, 8'h01);
        wr(O_CFG, 8'hFF);
        rd_chk(O_CFG, 8'h20);
        wr(O_PROT, 8'h00);
        rd_chk(O_PROT, 8'hFE);
        wr(O_ST, 8'h0B);
        rd_chk(O_ST, 8'hC0);
        rd_chk(5'h18, 8'h00);
        wr(FCSI_OFS_ARRAY, 8'h5A, 16'hFFB3);
        @(posedge core_clk);
        check({7'h00, key_seen}, 8'h01);
        check(key_d, 8'h5A);
        check(key_a[7:0], 8'hB3);
        wr(O_CFG, 8'h00);
        launch(16'h8000, FCSI_CMD_BYTE);
        wait_done();
        check(q, 8'hD0);
        wr(O_ST, 8'h00);
        rd_chk(O_ST, 8'hD0);
        wr(O_ST, 8'h10);
        rd_chk(O_ST, 8'hC0);
        wr(O_DIV, 8'h03);
        rd_chk(O_DIV, 8'h83);
        launch(16'h8000, 8'h33);
        wait_done();
        check(q, 8'hD0);
        wr(O_ST, 8'h10);
        for (int i = 0; i < 5; i++) begin
            launch(16'h8000, codes[i]);
            rd_chk(O_ST, 8'h80);
            check(array_cmd_o, codes[i]);
            check(array_data_o, 8'hA5);
            check(array_addr_o[15:8], 8'h80);
            wait_done();
            check(q, (i == 0) ? 8'hC4 : 8'hC0);
        end
        check({6'h00, security_code_o}, 8'h02);
        launch(16'h8000, FCSI_CMD_BYTE);
        wait_done();
        check(q, 8'hC0);
        dbg <= 1'b1;
        wr(O_PROT, 8'h81);
        dbg <= 1'b0;
        rd_chk(O_PROT, 8'h80);
        launch(16'hC000, FCSI_CMD_BYTE);
        wait_done();
        check(q, 8'hE0);
        wr(O_ST, 8'h20);
        rd_chk(O_ST, 8'hC0);
        launch(16'h8000, FCSI_CMD_BYTE);
        wait_done();
        check(q, 8'hC0);
        prot_dis <= 1'b1;
        launch(16'hFFB4, FCSI_CMD_BYTE);
        wait_done();
        check(q, 8'hC0);
        prot_dis <= 1'b0;
        erased <= 1'b0;
        launch(16'h8000, FCSI_CMD_BLANK);
        wait_done();
        check(q, 8'hC0);
        erased <= 1'b1;
        launch(16'h8000, FCSI_CMD_PAGE);
        stop_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        stop_req <= 1'b0;
        wait_done();
        check(q, 8'hD0);
        wr(O_ST, 8'h10);
        launch(16'h8001, FCSI_CMD_BURST);
        launch(16'h8002, FCSI_CMD_BURST);
        rd_chk(O_ST, 8'h00);
        wait_done();
        check(q, 8'hC0);
        launch(16'h8003, FCSI_CMD_BURST);
        launch(16'h8000, FCSI_CMD_PAGE);
        wait_done();
        check(q, 8'hD0);
        summarize();
    end
endmodule // fcsi_core_bench

// *** inc/fcsi_pkg.sv ***
// package for the flash command and status interface
// assumes a classic wishbone slave with 32-bit data, 8-bit registers
package fcsi_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] FCSI_OFS_DIVIDER = 4'h0;
    localparam logic [3:0] FCSI_OFS_CONFIG = 4'h4;
    localparam logic [3:0] FCSI_OFS_PROTECT = 4'h8;
    localparam logic [3:0] FCSI_OFS_STATUS = 4'hC;
    localparam logic [4:0] FCSI_OFS_COMMAND = 5'h10;
    localparam logic [4:0] FCSI_OFS_ARRAY = 5'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FCSI_CFG_KEYWR_BIT = 5;
    localparam int FCSI_ST_CBEF_BIT = 7;
    localparam int FCSI_ST_CCF_BIT = 6;
    localparam int FCSI_ST_PVIOL_BIT = 5;
    localparam int FCSI_ST_ACCERR_BIT = 4;
    localparam int FCSI_ST_BLANK_BIT = 2;
    localparam int FCSI_DIVIDER_LOADED_FLAG_BIT = 7;
    localparam int FCSI_PRDIV8_BIT = 6;
    localparam logic [7:0] FCSI_PROT_MASK = 8'hFE;
    localparam logic [7:0] FCSI_DIV_MASK = 8'h3F;
    localparam logic [1:0] FCSI_SEC_UNSECURED = 2'h2;
    // ------------------------------------------------------------
    // key window and commands
    // ------------------------------------------------------------
    localparam logic [15:0] FCSI_KEY_LO = 16'hFFB0;
    localparam logic [15:0] FCSI_KEY_HI = 16'hFFB7;
    localparam logic [7:0] FCSI_CMD_BLANK = 8'h05;
    localparam logic [7:0] FCSI_CMD_BYTE = 8'h20;
    localparam logic [7:0] FCSI_CMD_BURST = 8'h25;
    localparam logic [7:0] FCSI_CMD_PAGE = 8'h40;
    localparam logic [7:0] FCSI_CMD_MASS = 8'h41;
    localparam logic [7:0] FCSI_ERASED = 8'hFF;
    localparam int FCSI_PAGE_BYTES = 512;
    localparam logic [2:0] FCSI_PRE8 = 3'h7;

    typedef enum logic [1:0] {
        FCSI_SEQ_IDLE,
        FCSI_SEQ_DATA,
        FCSI_SEQ_CMD
    } fcsi_seq_e;

    typedef enum logic [1:0] {
        FCSI_EX_IDLE,
        FCSI_EX_RUN,
        FCSI_EX_DONE
    } fcsi_ex_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic [7:0] cmd;
    } fcsi_cmd_s;
endpackage

// *** verilog/fcsi_core.sv ***
// flash command and status interface: registers, decoder, sequencer
// assumes classic wishbone master, one clock, array modelled by port
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
// Function
// RULE1 - config register holds only bit five
// RULE2 - key bit steers window writes: key/command
// RULE3 - protect register loaded at reset, bit0 zero
// RULE4 - user writes ignored, debug writes update
// RULE5 - protect field bounds unprotected high region; code protects addresses above the bound instead
// RULE6 - status bits 3,1,0 read zero
// RULE7 - writing one to buffer-empty launches command
// RULE8 - only burst program may be queued
// RULE9 - complete flag set when idle, cleared launch
// RULE10 - protected target sets violation, drops command
// RULE11 - sequence, divider or stop errors set flag
// RULE12 - access error cleared only by one
// RULE13 - blank flag set when all bytes erased
// RULE14 - codes 05,20,25 blank, byte, burst
// RULE15 - codes 40,41 page and mass erase
// RULE16 - other codes illegal, access error raised
// RULE17 - blank check after mass erase optional
// RULE18 - program/erase disabled until divider written
// RULE19 - successful blank check unsecures security code
// RULE20 - complete low while busy, whole fclk pulses
module fcsi_core
    import fcsi_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int OP_PULSES = 4
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic dbg_access_i,
    input wire logic [7:0] nonvolatile_protect_copy_i,
    input wire logic [1:0] nv_security_i,
    input wire logic protection_disable_i,
    input wire logic stop_req_i,
    input wire logic array_word_erased_i,
    output logic key_write_o,
    output logic [15:0] key_addr_o,
    output logic [7:0] key_data_o,
    output logic array_busy_o,
    output logic [7:0] array_cmd_o,
    output logic [15:0] array_addr_o,
    output logic [7:0] array_data_o,
    output logic [1:0] security_code_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic cmd_legal(input logic [7:0] c);
        cmd_legal = (c == FCSI_CMD_BLANK) || (c == FCSI_CMD_BYTE) || // RULE14
            (c == FCSI_CMD_BURST) || (c == FCSI_CMD_PAGE) ||
            (c == FCSI_CMD_MASS); // RULE15
    endfunction

    function automatic logic is_prot(input logic [15:0] a,
            input logic [7:0] p, input logic dis, input logic [7:0] c);
        logic [15:0] lim;
        lim = {p[7:1], 9'h1FF};
        if (dis) begin
            is_prot = 1'b0;
        end else if (c == FCSI_CMD_MASS || c == FCSI_CMD_BLANK) begin
            is_prot = (c == FCSI_CMD_MASS) && (lim != 16'hFFFF);
        end else begin
            is_prot = a > lim;
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic cfg_key_reg, cfg_key_next;
    logic [7:0] prot_reg, prot_next;
    logic prot_loaded_reg, prot_loaded_next;
    logic [7:0] div_reg, div_next;
    logic cbef_reg, cbef_next;
    logic pviol_reg, pviol_next;
    logic accerr_reg, accerr_next;
    logic blank_reg, blank_next;
    logic [1:0] sec_reg, sec_next;
    fcsi_seq_e seq_reg, seq_next;
    fcsi_ex_e ex_reg, ex_next;
    fcsi_cmd_s buf_reg, buf_next, run_reg, run_next;
    logic buf_full_reg, buf_full_next;
    logic [8:0] pre_reg, pre_next;
    logic [7:0] pulse_reg, pulse_next;
    logic all_ff_reg, all_ff_next;
    logic kw_reg, kw_next;
    logic [15:0] kaddr_reg, kaddr_next;
    logic [7:0] kdata_reg, kdata_next;

    logic req, wr, rd;
    logic [4:0] ofs;
    logic [7:0] wbyte;
    logic fclk_tick;
    logic [8:0] pre_top;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign ofs = wb_adr_i[4:0];
    assign wbyte = wb_dat_i[7:0];
    assign pre_top = div_reg[FCSI_PRDIV8_BIT] ?
        {div_reg[5:0], FCSI_PRE8} : {3'h0, div_reg[5:0]};
    assign fclk_tick = (pre_reg == pre_top);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic launch, drop, in_win, ccf;
        launch = 1'b0;
        drop = 1'b0;
        in_win = 1'b0;
        ccf = 1'b0;
        ack_next = req;
        rdat_next = rdat_reg;
        cfg_key_next = cfg_key_reg;
        prot_next = prot_reg;
        prot_loaded_next = 1'b1;
        div_next = div_reg;
        cbef_next = cbef_reg;
        pviol_next = pviol_reg;
        accerr_next = accerr_reg;
        blank_next = blank_reg;
        sec_next = sec_reg;
        seq_next = seq_reg;
        ex_next = ex_reg;
        buf_next = buf_reg;
        run_next = run_reg;
        buf_full_next = buf_full_reg;
        pre_next = fclk_tick ? 9'h000 : 9'(pre_reg + 9'h001);
        pulse_next = pulse_reg;
        all_ff_next = all_ff_reg;
        kw_next = 1'b0;
        kaddr_next = kaddr_reg;
        kdata_next = kdata_reg;
        if (!prot_loaded_reg) begin
            prot_next = nonvolatile_protect_copy_i & FCSI_PROT_MASK; // RULE3
            sec_next = nv_security_i;
        end
        ccf = (ex_reg == FCSI_EX_IDLE) && !buf_full_reg; // RULE9 RULE20
        if (wr) begin
            case (ofs)
                5'(FCSI_OFS_DIVIDER): begin
                    div_next = (wbyte & {1'b0, 1'b1, FCSI_DIV_MASK[5:0]}) |
                        8'h80; // RULE18
                end
                5'(FCSI_OFS_CONFIG): begin
                    cfg_key_next = wbyte[FCSI_CFG_KEYWR_BIT]; // RULE1
                end
                5'(FCSI_OFS_PROTECT): begin
                    if (dbg_access_i) begin
                        prot_next = wbyte & FCSI_PROT_MASK; // RULE4
                    end
                end
                5'(FCSI_OFS_STATUS): begin
                    if (wbyte[FCSI_ST_PVIOL_BIT]) begin
                        pviol_next = 1'b0; // RULE10
                    end
                    if (wbyte[FCSI_ST_ACCERR_BIT]) begin
                        accerr_next = 1'b0; // RULE12
                    end
                    if (wbyte[FCSI_ST_CBEF_BIT] && cbef_reg) begin
                        if (seq_reg == FCSI_SEQ_CMD) begin
                            launch = 1'b1; // RULE7
                        end else begin
                            accerr_next = 1'b1; // RULE11
                            seq_next = FCSI_SEQ_IDLE;
                        end
                    end
                end
                FCSI_OFS_COMMAND: begin
                    if (seq_reg == FCSI_SEQ_DATA) begin
                        buf_next.cmd = wbyte;
                        seq_next = FCSI_SEQ_CMD;
                    end else begin
                        accerr_next = 1'b1; // RULE11
                        seq_next = FCSI_SEQ_IDLE;
                    end
                end
                FCSI_OFS_ARRAY: begin
                    in_win = (wb_adr_i[31:16] >= FCSI_KEY_LO) &&
                        (wb_adr_i[31:16] <= FCSI_KEY_HI);
                    if (in_win && cfg_key_reg) begin
                        kw_next = 1'b1; // RULE2
                        kaddr_next = wb_adr_i[31:16];
                        kdata_next = wbyte;
                    end else if (seq_reg == FCSI_SEQ_IDLE && cbef_reg) begin
                        buf_next.addr = wb_adr_i[31:16]; // RULE2
                        buf_next.data = wbyte;
                        seq_next = FCSI_SEQ_DATA;
                    end else begin
                        accerr_next = 1'b1; // RULE11
                        seq_next = FCSI_SEQ_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        if (launch) begin
            seq_next = FCSI_SEQ_IDLE;
            if (!cmd_legal(buf_reg.cmd)) begin
                accerr_next = 1'b1; // RULE16
                drop = 1'b1;
            end else if (!div_reg[FCSI_DIVIDER_LOADED_FLAG_BIT] &&
                    buf_reg.cmd != FCSI_CMD_BLANK) begin
                accerr_next = 1'b1; // RULE11 RULE18
                drop = 1'b1;
            end else if (is_prot(buf_reg.addr, prot_reg,
                    protection_disable_i, buf_reg.cmd)) begin
                pviol_next = 1'b1; // RULE5 RULE10
                drop = 1'b1;
            end else if (ex_reg != FCSI_EX_IDLE &&
                    !(buf_reg.cmd == FCSI_CMD_BURST &&
                    run_reg.cmd == FCSI_CMD_BURST)) begin
                accerr_next = 1'b1; // RULE8
                drop = 1'b1;
            end
            if (!drop) begin
                blank_next = 1'b0; // RULE13
                cbef_next = 1'b0; // RULE7
                buf_full_next = 1'b1;
            end
        end
        case (ex_reg)
            FCSI_EX_IDLE: begin
                if (buf_full_reg) begin
                    run_next = buf_reg;
                    buf_full_next = 1'b0;
                    cbef_next = 1'b1; // RULE7 RULE8
                    pulse_next = 8'h00;
                    all_ff_next = 1'b1;
                    ex_next = FCSI_EX_RUN;
                end
            end
            FCSI_EX_RUN: begin
                if (stop_req_i) begin
                    accerr_next = 1'b1; // RULE11
                    buf_full_next = 1'b0;
                    cbef_next = 1'b1;
                    ex_next = FCSI_EX_IDLE;
                end else if (fclk_tick) begin
                    pulse_next = 8'(pulse_reg + 8'h01); // RULE20
                    if (run_reg.cmd == FCSI_CMD_BLANK &&
                            !array_word_erased_i) begin
                        all_ff_next = 1'b0; // RULE13
                    end
                    if (pulse_reg == 8'(OP_PULSES - 1)) begin
                        ex_next = FCSI_EX_DONE;
                    end
                end
            end
            FCSI_EX_DONE: begin
                if (run_reg.cmd == FCSI_CMD_BLANK && all_ff_reg) begin
                    blank_next = 1'b1; // RULE13
                    sec_next = FCSI_SEC_UNSECURED; // RULE19
                end
                ex_next = FCSI_EX_IDLE;
            end
            default: begin
                ex_next = FCSI_EX_IDLE;
            end
        endcase
        if (rd) begin
            rdat_next = 32'h0000_0000;
            case (ofs)
                5'(FCSI_OFS_DIVIDER): rdat_next[7:0] = div_reg;
                5'(FCSI_OFS_CONFIG): begin
                    rdat_next[FCSI_CFG_KEYWR_BIT] = cfg_key_reg; // RULE1
                end
                5'(FCSI_OFS_PROTECT): begin
                    rdat_next[7:0] = prot_reg & FCSI_PROT_MASK; // RULE3
                end
                5'(FCSI_OFS_STATUS): begin
                    rdat_next[FCSI_ST_CBEF_BIT] = cbef_reg; // RULE6
                    rdat_next[FCSI_ST_CCF_BIT] = ccf;
                    rdat_next[FCSI_ST_PVIOL_BIT] = pviol_reg;
                    rdat_next[FCSI_ST_ACCERR_BIT] = accerr_reg;
                    rdat_next[FCSI_ST_BLANK_BIT] = blank_reg;
                end
                FCSI_OFS_COMMAND: rdat_next[7:0] = buf_reg.cmd;
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            cfg_key_reg <= 1'b0;
            prot_reg <= 8'h00;
            prot_loaded_reg <= 1'b0;
            div_reg <= 8'h00;
            cbef_reg <= 1'b1;
            pviol_reg <= 1'b0;
            accerr_reg <= 1'b0;
            blank_reg <= 1'b0;
            sec_reg <= 2'h0;
            seq_reg <= FCSI_SEQ_IDLE;
            ex_reg <= FCSI_EX_IDLE;
            buf_reg <= '0;
            run_reg <= '0;
            buf_full_reg <= 1'b0;
            pre_reg <= 9'h000;
            pulse_reg <= 8'h00;
            all_ff_reg <= 1'b0;
            kw_reg <= 1'b0;
            kaddr_reg <= 16'h0000;
            kdata_reg <= 8'h00;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            cfg_key_reg <= cfg_key_next;
            prot_reg <= prot_next;
            prot_loaded_reg <= prot_loaded_next;
            div_reg <= div_next;
            cbef_reg <= cbef_next;
            pviol_reg <= pviol_next;
            accerr_reg <= accerr_next;
            blank_reg <= blank_next;
            sec_reg <= sec_next;
            seq_reg <= seq_next;
            ex_reg <= ex_next;
            buf_reg <= buf_next;
            run_reg <= run_next;
            buf_full_reg <= buf_full_next;
            pre_reg <= pre_next;
            pulse_reg <= pulse_next;
            all_ff_reg <= all_ff_next;
            kw_reg <= kw_next;
            kaddr_reg <= kaddr_next;
            kdata_reg <= kdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign key_write_o = kw_reg;
    assign key_addr_o = kaddr_reg;
    assign key_data_o = kdata_reg;
    assign array_busy_o = (ex_reg != FCSI_EX_IDLE);
    assign array_cmd_o = run_reg.cmd;
    assign array_addr_o = run_reg.addr;
    assign array_data_o = run_reg.data;
    assign security_code_o = sec_reg;
endmodule // fcsi_core
